// ==== hw/mth_datapath.sv ====
// Purpose : Dual multiply-accumulate into an accumulator, copied formatted into a half data register
// Assumes : Decoder presents one request per cycle at most; operands are read by the register file
// Notes   : Result and flags appear one cycle after the request
`default_nettype none
`include "mth_map.svh"

// Behaviour
// - Multiply two 16-bit halves; load, add or subtract product into the accumulator.
// - Write 16 accumulator bits, saturated to 16 bits, into a destination half.
// - Unit zero uses acc_zero and low half; unit one uses acc_one and high half.
// - Rounding options use rounding_select_bit for biased or unbiased rounding.
// - Default: signed fractions shifted left; copy high half rounded and saturated.
// - Unsigned fraction: unsigned operands, no shift; copy high half rounded, saturated unsigned.
// - Signed or unsigned integer: no shift; copy low half saturated to 16 bits.
// - Chop options copy saturated high half, dropping low half; unsigned variant unshifted.
// - Double and round: signed fractions, accumulator x2, round upper 16, saturate.
// - Integer doubling: signed integers unshifted, accumulator x2, copy low half saturated.
// - Integer high: signed integers, saturate accumulator at 32 bits, round upper 16.
// - Mixed option: unit one only, signed by unsigned fractions, no shift.
// - Truncation discards low accumulator bits that do not fit the half.
// - Round first, saturate afterwards.
// - Signed fractional 0x8000 times 0x8000 becomes largest positive fraction before accumulating.
// - Every form is decoded from one 32-bit instruction word.
// - Result saturation flag follows each write; its sticky copy sets until a status write clears it.
// - Per-unit accumulator saturation flag follows each update; sticky copy sets until a status write clears it.
module mth_datapath (
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rst_b,
  // Instruction and operands
  input  wire mth_pkg::mth_req_type req,
  // Half-register write
  output var  mth_pkg::mth_wr_type  wr_ff,
  // Register port
  input  wire logic [7:0]         reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output var  logic [31:0]        reg_rdata_ff
);

  // ==========================================================
  // State
  logic [39:0] acc_zero_ff;
  logic [39:0] acc_one_ff;
  logic        rounding_select_bit_ff;
  logic        result_saturated_flag_ff;
  logic        result_saturated_sticky_ff;
  logic        acc0_saturated_flag_ff;
  logic        acc0_saturated_sticky_ff;
  logic        acc1_saturated_flag_ff;
  logic        acc1_saturated_sticky_ff;

  // ==========================================================
  // Decode
  logic                    go;
  logic                    unit;
  logic                    mixed;
  mth_pkg::mth_opt_type    opt;
  mth_pkg::mth_acc_op_type aop;

  always_comb begin
    aop   = mth_pkg::mth_acc_op_type'(req.instr[`MTH_INS_ACC_HI:`MTH_INS_ACC_LO]);
    opt   = mth_pkg::mth_opt_type'(req.instr[`MTH_INS_OPT_HI:`MTH_INS_OPT_LO]);
    unit  = req.instr[`MTH_INS_UNIT];
    mixed = req.instr[`MTH_INS_MIXED] & unit;
    // Unknown class, option or accumulate code is dropped with no effect
    go    = req.valid && (req.instr[`MTH_INS_CLASS_HI:`MTH_INS_CLASS_LO] == `MTH_INS_CLASS_CODE)
            && (aop != mth_pkg::ACC_BAD) && (opt <= mth_pkg::OPT_INTEGER_HIGH_ROUND);
  end

  // ==========================================================
  // Datapath
  logic               nxt_acc_sat;
  logic               nxt_res_sat;
  logic [39:0]        nxt_acc;
  logic [15:0]        nxt_half;
  logic signed [16:0] a17;
  logic signed [16:0] b17;
  logic signed [33:0] prod;
  logic signed [41:0] p42;
  logic signed [41:0] acc42;
  logic signed [41:0] sum;
  logic signed [41:0] v;
  logic signed [41:0] sel;

  always_comb begin
    logic               s0_signed;
    logic               s1_signed;
    logic               shift_fix;
    logic               out_uns;
    logic               do_round;
    logic               take_low;
    s0_signed = 1'b1;
    s1_signed = 1'b1;
    shift_fix = 1'b0;
    out_uns   = 1'b0;
    do_round  = 1'b0;
    take_low  = 1'b0;
    case (opt)
      mth_pkg::OPT_DEFAULT: begin
        shift_fix = 1'b1;
        do_round  = 1'b1;
      end
      mth_pkg::OPT_UNSIGNED_FRACTION_OPT: begin
        s0_signed = 1'b0;
        s1_signed = 1'b0;
        out_uns   = 1'b1;
        do_round  = 1'b1;
      end
      mth_pkg::OPT_SIGNED_INTEGER_OPT: begin
        take_low  = 1'b1;
      end
      mth_pkg::OPT_UNSIGNED_INT_OPT: begin
        s0_signed = 1'b0;
        s1_signed = 1'b0;
        out_uns   = 1'b1;
        take_low  = 1'b1;
      end
      mth_pkg::OPT_FRACTION_CHOP: begin
        shift_fix = 1'b1;
      end
      mth_pkg::OPT_UNSIGNED_FRACTION_CHOP: begin
        s0_signed = 1'b0;
        s1_signed = 1'b0;
        out_uns   = 1'b1;
      end
      mth_pkg::OPT_DOUBLE_AND_ROUND: begin
        shift_fix = 1'b1;
        do_round  = 1'b1;
      end
      mth_pkg::OPT_INT_DOUBLE_LOW: begin
        take_low  = 1'b1;
      end
      mth_pkg::OPT_INTEGER_HIGH_ROUND: begin
        do_round  = 1'b1;
      end
      default: begin
        shift_fix = 1'b1;
        do_round  = 1'b1;
      end
    endcase
    // Mixed overrides operand treatment and forces signed saturation; rounding and half choice stay with the paired option
    if (mixed) begin
      s0_signed = 1'b1;
      s1_signed = 1'b0;
      shift_fix = 1'b0;
      out_uns   = 1'b0;
    end
    a17  = {s0_signed & req.src0[15], req.src0};
    b17  = {s1_signed & req.src1[15], req.src1};
    prod = a17 * b17;
    if (shift_fix) begin
      if (req.src0 == `MTH_MOST_NEG && req.src1 == `MTH_MOST_NEG) begin
        prod = `MTH_FRAC_MAX_PROD;
      end else begin
        prod = prod <<< 1;
      end
    end
    p42   = 42'(prod);
    acc42 = 42'(signed'(unit ? acc_one_ff : acc_zero_ff));
    case (aop)
      mth_pkg::ACC_ADD: sum = acc42 + p42;
      mth_pkg::ACC_SUB: sum = acc42 - p42;
      default:          sum = p42;
    endcase
    nxt_acc_sat = 1'b1;
    if (sum > `MTH_ACC_MAX) begin
      sum = `MTH_ACC_MAX;
    end else if (sum < `MTH_ACC_MIN) begin
      sum = `MTH_ACC_MIN;
    end else begin
      nxt_acc_sat = 1'b0;
    end
    nxt_acc = sum[39:0];
    // Copy formatting
    v = sum;
    if (opt == mth_pkg::OPT_INTEGER_HIGH_ROUND) begin
      if (v > `MTH_W32_MAX) begin
        v = `MTH_W32_MAX;
      end else if (v < `MTH_W32_MIN) begin
        v = `MTH_W32_MIN;
      end
    end
    if (opt == mth_pkg::OPT_DOUBLE_AND_ROUND || opt == mth_pkg::OPT_INT_DOUBLE_LOW) begin
      v = v <<< 1;
    end
    if (take_low) begin
      sel = v;
    end else if (do_round) begin
      sel = (v + `MTH_ROUND_HALF) >>> 16;
      // Unbiased: an exact half goes to the even neighbour
      if (!rounding_select_bit_ff && v[15:0] == 16'h8000) begin
        sel[0] = 1'b0;
      end
    end else begin
      sel = v >>> 16;
    end
    // Saturation comes last, after any rounding
    nxt_res_sat = 1'b1;
    if (out_uns) begin
      if (sel > 42'sh0000000FFFF) begin
        nxt_half = 16'hFFFF;
      end else if (sel < 42'sh0) begin
        nxt_half = 16'h0000;
      end else begin
        nxt_half    = sel[15:0];
        nxt_res_sat = 1'b0;
      end
    end else begin
      if (sel > 42'sh00000007FFF) begin
        nxt_half = 16'h7FFF;
      end else if (sel < -42'sh00000008000) begin
        nxt_half = 16'h8000;
      end else begin
        nxt_half    = sel[15:0];
        nxt_res_sat = 1'b0;
      end
    end
  end

  // ==========================================================
  // Accumulators
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_zero_ff <= 40'h0;
      acc_one_ff  <= 40'h0;
    end else if (go) begin
      if (unit) begin
        acc_one_ff  <= nxt_acc;
      end else begin
        acc_zero_ff <= nxt_acc;
      end
    end
  end

  // ==========================================================
  // Half-register write
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ff <= '0;
    end else begin
      wr_ff.valid          <= go;
      wr_ff.dest           <= req.instr[`MTH_INS_DEST_HI:`MTH_INS_DEST_LO];
      wr_ff.high_half_dest <= unit;
      wr_ff.data           <= nxt_half;
    end
  end

  // ==========================================================
  // Flags: hardware set wins over a software clear in the same cycle
  logic clr_ok;
  assign clr_ok = reg_wr && (reg_addr == `MTH_OFS_STATUS);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      result_saturated_flag_ff   <= 1'b0;
      result_saturated_sticky_ff <= 1'b0;
    end else begin
      if (go) begin
        result_saturated_flag_ff <= nxt_res_sat;
      end
      if (go && nxt_res_sat) begin
        result_saturated_sticky_ff <= 1'b1;
      end else if (clr_ok && reg_wdata[`MTH_BIT_RES_STK]) begin
        result_saturated_sticky_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc0_saturated_flag_ff   <= 1'b0;
      acc0_saturated_sticky_ff <= 1'b0;
      acc1_saturated_flag_ff   <= 1'b0;
      acc1_saturated_sticky_ff <= 1'b0;
    end else begin
      if (go && !unit) begin
        acc0_saturated_flag_ff <= nxt_acc_sat;
      end
      if (go && unit) begin
        acc1_saturated_flag_ff <= nxt_acc_sat;
      end
      if (go && !unit && nxt_acc_sat) begin
        acc0_saturated_sticky_ff <= 1'b1;
      end else if (clr_ok && reg_wdata[`MTH_BIT_ACC0_STK]) begin
        acc0_saturated_sticky_ff <= 1'b0;
      end
      if (go && unit && nxt_acc_sat) begin
        acc1_saturated_sticky_ff <= 1'b1;
      end else if (clr_ok && reg_wdata[`MTH_BIT_ACC1_STK]) begin
        acc1_saturated_sticky_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Register port
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rounding_select_bit_ff <= `MTH_RST_RND;
    end else if (clr_ok) begin
      rounding_select_bit_ff <= reg_wdata[`MTH_BIT_RND];
    end
  end

  logic [31:0] status_word;
  always_comb begin
    status_word                    = 32'h0;
    status_word[`MTH_BIT_RND]      = rounding_select_bit_ff;
    status_word[`MTH_BIT_RES_SAT]  = result_saturated_flag_ff;
    status_word[`MTH_BIT_RES_STK]  = result_saturated_sticky_ff;
    status_word[`MTH_BIT_ACC0_SAT] = acc0_saturated_flag_ff;
    status_word[`MTH_BIT_ACC0_STK] = acc0_saturated_sticky_ff;
    status_word[`MTH_BIT_ACC1_SAT] = acc1_saturated_flag_ff;
    status_word[`MTH_BIT_ACC1_STK] = acc1_saturated_sticky_ff;
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_ff <= 32'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        `MTH_OFS_STATUS:   reg_rdata_ff <= status_word;
        `MTH_OFS_ACC0_LO:  reg_rdata_ff <= acc_zero_ff[31:0];
        `MTH_OFS_ACC0_EXT: reg_rdata_ff <= {24'h0, acc_zero_ff[39:32]};
        `MTH_OFS_ACC1_LO:  reg_rdata_ff <= acc_one_ff[31:0];
        `MTH_OFS_ACC1_EXT: reg_rdata_ff <= {24'h0, acc_one_ff[39:32]};
        default:           reg_rdata_ff <= 32'h0;
      endcase
    end else begin
      reg_rdata_ff <= 32'h0;
    end
  end

endmodule : mth_datapath

`default_nettype wire

// ==== hw/mth_map.svh ====
// Purpose : Offsets, field positions, reset values and codes of the half-register MAC datapath
// Assumes : Included by the datapath module only
// Notes   : Definitions only
`ifndef MTH_MAP_SVH
`define MTH_MAP_SVH

// ==========================================================
// Register offsets (byte addresses, one word each)
`define MTH_OFS_STATUS      8'h00
`define MTH_OFS_ACC0_LO     8'h04
`define MTH_OFS_ACC0_EXT    8'h08
`define MTH_OFS_ACC1_LO     8'h0C
`define MTH_OFS_ACC1_EXT    8'h10

// ==========================================================
// Status register fields
`define MTH_BIT_RND         0
`define MTH_BIT_RES_SAT     1
`define MTH_BIT_RES_STK     2
`define MTH_BIT_ACC0_SAT    3
`define MTH_BIT_ACC0_STK    4
`define MTH_BIT_ACC1_SAT    5
`define MTH_BIT_ACC1_STK    6
`define MTH_RST_RND         1'h0

// ==========================================================
// Instruction word fields
`define MTH_INS_CLASS_HI    31
`define MTH_INS_CLASS_LO    28
`define MTH_INS_CLASS_CODE  4'hC
`define MTH_INS_DEST_HI     10
`define MTH_INS_DEST_LO     8
`define MTH_INS_MIXED       7
`define MTH_INS_OPT_HI      6
`define MTH_INS_OPT_LO      3
`define MTH_INS_UNIT        2
`define MTH_INS_ACC_HI      1
`define MTH_INS_ACC_LO      0

// ==========================================================
// Arithmetic constants
`define MTH_ACC_MAX         42'sh07FFFFFFFFF
`define MTH_ACC_MIN         -42'sh08000000000
`define MTH_W32_MAX         42'sh0007FFFFFFF
`define MTH_W32_MIN         -42'sh00080000000
`define MTH_FRAC_MAX_PROD   34'sh07FFFFFFF
`define MTH_MOST_NEG        16'h8000
`define MTH_ROUND_HALF      42'sh00000008000

`endif

// ==== hw/mth_pkg.sv ====
// Purpose : Types shared by the half-register MAC datapath
// Assumes : Compiled before the datapath
// Notes   : Constants live in mth_map.svh
`default_nettype none

package mth_pkg;

  // ==========================================================
  // Accumulate operation
  typedef enum logic [1:0] {
    ACC_LOAD = 2'h0,
    ACC_ADD  = 2'h1,
    ACC_SUB  = 2'h2,
    ACC_BAD  = 2'h3
  } mth_acc_op_type;

  // ==========================================================
  // Format options
  typedef enum logic [3:0] {
    OPT_DEFAULT                = 4'h0,
    OPT_UNSIGNED_FRACTION_OPT  = 4'h1,
    OPT_SIGNED_INTEGER_OPT     = 4'h2,
    OPT_UNSIGNED_INT_OPT       = 4'h3,
    OPT_FRACTION_CHOP          = 4'h4,
    OPT_UNSIGNED_FRACTION_CHOP = 4'h5,
    OPT_DOUBLE_AND_ROUND       = 4'h6,
    OPT_INT_DOUBLE_LOW         = 4'h7,
    OPT_INTEGER_HIGH_ROUND     = 4'h8
  } mth_opt_type;

  // ==========================================================
  // Request from the decoder and register file
  typedef struct packed {
    logic        valid;
    logic [31:0] instr;
    logic [15:0] src0;
    logic [15:0] src1;
  } mth_req_type;

  // Half-register write to the register file
  typedef struct packed {
    logic        valid;
    logic [2:0]  dest;
    logic        high_half_dest;
    logic [15:0] data;
  } mth_wr_type;

endpackage : mth_pkg

`default_nettype wire

// ==== sim/mth_datapath_props.sv ====
// Purpose : Port-level properties of the half-register MAC datapath
// Assumes : Bound to mth_datapath; one clock domain
// Notes   : Acceptance decode repeats the instruction field layout
`default_nettype none

module mth_datapath_props (
  // Clock and reset
  input wire logic                 sys_clk,
  input wire logic                 rst_b,
  // Instruction path
  input wire mth_pkg::mth_req_type req,
  input wire mth_pkg::mth_wr_type  wr_ff,
  // Register port
  input wire logic [7:0]           reg_addr,
  input wire logic [31:0]          reg_wdata,
  input wire logic                 reg_wr,
  input wire logic                 reg_rd,
  input wire logic [31:0]          reg_rdata_ff
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // ==========================================================
  // Helper decode
  logic take;
  logic ld;
  assign take = req.valid && req.instr[31:28] == 4'hC && req.instr[1:0] != 2'h3 && req.instr[6:3] <= 4'h8;
  assign ld   = take && req.instr[1:0] == 2'h0;

  // ==========================================================
  // Assertions
  write_follows_a: assert property (take |=> wr_ff.valid)
    else $error("no write after accepted request");
  refuse_none_a: assert property (!take |=> !wr_ff.valid)
    else $error("write without accepted request");
  half_sel_a: assert property (take |=> wr_ff.high_half_dest == $past(req.instr[2]))
    else $error("wrong destination half");
  dest_idx_a: assert property (take |=> wr_ff.dest == $past(req.instr[10:8]))
    else $error("wrong destination index");
  frac_corner_a: assert property (ld && req.instr[6:3] == 4'h0 && !req.instr[2] && req.src0 == 16'h8000
    && req.src1 == 16'h8000 |=> wr_ff.data == 16'h7FFF) else $error("corner product not forced");
  int_pass_a: assert property (ld && req.instr[6:3] == 4'h2 && !req.instr[2] && req.src1 == 16'h0001
    |=> wr_ff.data == $past(req.src0)) else $error("integer low copy wrong");
  load_zero_a: assert property (ld && req.src0 == 16'h0000 |=> wr_ff.data == 16'h0000)
    else $error("zero product not zero");
  mix_unit0_a: assert property (ld && req.instr[6:3] == 4'h0 && !req.instr[2] && req.src0 == 16'hFFFF
    && req.src1 == 16'hFFFF |=> wr_ff.data == 16'h0000) else $error("mixed applied to unit zero");

  // ==========================================================
  // Coverage
  add_seen_c: cover property (take && req.instr[1:0] == 2'h1);
  mixed_seen_c: cover property (take && req.instr[7] && req.instr[2]);
  status_wr_c: cover property (reg_wr && reg_addr == 8'h00);
endmodule : mth_datapath_props

`default_nettype wire

// ==== sim/mth_datapath_tb.sv ====
// Purpose : Self-checking bench of the half-register MAC datapath
// Assumes : One-cycle result latency, register read data one cycle later
// Notes   : Overflow case accumulates 258 corner products on unit one
`default_nettype none

module mth_datapath_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 sys_clk   = 1'b0;
  logic                 rst_b     = 1'b0;
  mth_pkg::mth_req_type req       = '0;
  mth_pkg::mth_wr_type  wr_ff;
  logic [7:0]           reg_addr  = 8'h00;
  logic [31:0]          reg_wdata = 32'h0;
  logic                 reg_wr    = 1'b0;
  logic                 reg_rd    = 1'b0;
  logic [31:0]          reg_rdata_ff;
  logic [31:0]          rd_data;
  logic [31:0]          rv;
  logic [55:0]          r;
  int                   n_fail    = 0;
  int                   cmp_count = 0;
  // Fields: op, unit, option, mixed, src0, src1, expected half
  localparam logic [55:0] ROWS [17] = '{
    {2'h0, 1'h0, 4'h0, 1'h0, 16'h4000, 16'h4000, 16'h2000},
    {2'h0, 1'h1, 4'h0, 1'h0, 16'h2000, 16'h4000, 16'h1000},
    {2'h1, 1'h0, 4'h0, 1'h0, 16'h4000, 16'h4000, 16'h4000},
    {2'h2, 1'h0, 4'h0, 1'h0, 16'h4000, 16'h4000, 16'h2000},
    {2'h0, 1'h0, 4'h1, 1'h0, 16'hFFFF, 16'hFFFF, 16'hFFFE},
    {2'h0, 1'h0, 4'h2, 1'h0, 16'hFFFA, 16'h0001, 16'hFFFA},
    {2'h0, 1'h0, 4'h2, 1'h0, 16'h7FFF, 16'h7FFF, 16'h7FFF},
    {2'h0, 1'h0, 4'h3, 1'h0, 16'hFFFF, 16'h0002, 16'hFFFF},
    {2'h0, 1'h0, 4'h4, 1'h0, 16'h4000, 16'h4003, 16'h2001},
    {2'h0, 1'h0, 4'h5, 1'h0, 16'h8003, 16'h8000, 16'h4001},
    {2'h0, 1'h0, 4'h6, 1'h0, 16'h2000, 16'h2000, 16'h1000},
    {2'h0, 1'h0, 4'h7, 1'h0, 16'h0064, 16'h0003, 16'h0258},
    {2'h0, 1'h0, 4'h8, 1'h0, 16'h4000, 16'h4000, 16'h1000},
    {2'h0, 1'h1, 4'h0, 1'h1, 16'hFFFF, 16'hFFFF, 16'hFFFF},
    {2'h0, 1'h0, 4'h0, 1'h1, 16'hFFFF, 16'hFFFF, 16'h0000},
    {2'h0, 1'h1, 4'h2, 1'h1, 16'hFFFF, 16'hFFFF, 16'h8000},
    {2'h0, 1'h0, 4'h0, 1'h0, 16'h4000, 16'h4001, 16'h2000}
  };

  always #2.5 sys_clk = ~sys_clk;

  mth_datapath u_mth_datapath (.sys_clk(sys_clk), .rst_b(rst_b), .req(req), .wr_ff(wr_ff), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff));
  mth_regfile_model u_mth_regfile_model (.sys_clk(sys_clk), .rst_b(rst_b), .wr(wr_ff), .rd_idx(3'h1),
    .rd_data(rd_data));

  // ==========================================================
  // Tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic logic [31:0] mk(input logic [1:0] op, input logic unit, input logic [3:0] opt,
                                     input logic mix, input logic [2:0] dest);
    return {4'hC, 17'h00000, dest, mix, opt, unit, op};
  endfunction : mk

  task automatic issue(input logic [31:0] ins, input logic [15:0] s0, input logic [15:0] s1);
    @(posedge sys_clk);
    req <= {1'b1, ins, s0, s1};
    @(posedge sys_clk);
    req.valid <= 1'b0;
    #1;
  endtask : issue

  task automatic run(input logic [31:0] ins, input logic [15:0] s0, input logic [15:0] s1,
                     input logic [15:0] exp, input logic hi);
    issue(ins, s0, s1);
    check("write valid", wr_ff.valid, 32'h1);
    check("half data", wr_ff.data, exp);
    check("half select", wr_ff.high_half_dest, hi);
  endtask : run

  task automatic reg_acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= w;
    reg_rd    <= !w;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
    rv = reg_rdata_ff;
  endtask : reg_acc

  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  // ==========================================================
  // Sequence
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    reg_acc(1'b0, 8'h00, 32'h0);
    check("status reset", rv, 32'h0);
    reg_acc(1'b0, 8'h20, 32'h0);
    check("unmapped read", rv, 32'h0);
    foreach (ROWS[i]) begin
      r = ROWS[i];
      run(mk(r[55:54], r[53], r[52:49], r[48], (i < 2) ? 3'h1 : 3'h2), r[47:32], r[31:16], r[15:0], r[53]);
    end
    check("low and high halves", rd_data, 32'h10002000);
    run(mk(2'h0, 1'h0, 4'h0, 1'h0, 3'h2), 16'h8000, 16'h8000, 16'h7FFF, 1'b0);
    reg_acc(1'b0, 8'h04, 32'h0);
    check("acc0 low word", rv, 32'h7FFFFFFF);
    reg_acc(1'b0, 8'h00, 32'h0);
    check("status saturated", rv, 32'h06);
    run(mk(2'h0, 1'h0, 4'h0, 1'h0, 3'h2), 16'h4000, 16'h4000, 16'h2000, 1'b0);
    reg_acc(1'b0, 8'h00, 32'h0);
    check("status sticky", rv, 32'h04);
    reg_acc(1'b1, 8'h00, 32'h04);
    reg_acc(1'b0, 8'h00, 32'h0);
    check("status cleared", rv, 32'h0);
    // Bad class, accumulate code 3, option 9: nothing is written
    issue(32'h0, 16'h1, 16'h1);
    check("refused class", wr_ff.valid, 32'h0);
    issue(mk(2'h3, 1'h0, 4'h0, 1'h0, 3'h2), 16'h1, 16'h1);
    check("refused op", wr_ff.valid, 32'h0);
    issue(mk(2'h0, 1'h0, 4'h9, 1'h0, 3'h2), 16'h1, 16'h1);
    check("refused option", wr_ff.valid, 32'h0);
    // Drive acc_one past the 40-bit range
    issue(mk(2'h0, 1'h1, 4'h0, 1'h0, 3'h3), 16'h8000, 16'h8000);
    repeat (257) issue(mk(2'h1, 1'h1, 4'h0, 1'h0, 3'h3), 16'h8000, 16'h8000);
    check("saturated copy", wr_ff.data, 32'h7FFF);
    reg_acc(1'b0, 8'h10, 32'h0);
    check("acc1 extension", rv, 32'h7F);
    reg_acc(1'b0, 8'h0C, 32'h0);
    check("acc1 low word", rv, 32'hFFFFFFFF);
    reg_acc(1'b0, 8'h00, 32'h0);
    check("status acc overflow", rv, 32'h66);
    run(mk(2'h1, 1'h1, 4'h8, 1'h0, 3'h3), 16'h0, 16'h0, 16'h7FFF, 1'b1);
    run(mk(2'h0, 1'h1, 4'h0, 1'h0, 3'h3), 16'h0, 16'h0, 16'h0, 1'b1);
    reg_acc(1'b0, 8'h00, 32'h0);
    check("status acc sticky", rv, 32'h44);
    // Biased rounding on an exact tie
    reg_acc(1'b1, 8'h00, 32'h01);
    run(mk(2'h0, 1'h0, 4'h0, 1'h0, 3'h2), 16'h4000, 16'h4001, 16'h2001, 1'b0);
    // Negative product shows up in the extension byte
    run(mk(2'h0, 1'h0, 4'h0, 1'h0, 3'h2), 16'h8000, 16'h4000, 16'hC000, 1'b0);
    reg_acc(1'b0, 8'h08, 32'h0);
    check("acc0 extension", rv, 32'hFF);
    // Second reset in mid-run: flags, rounding select and accumulators return to zero
    @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    reg_acc(1'b0, 8'h00, 32'h0);
    check("status after reset", rv, 32'h0);
    reg_acc(1'b0, 8'h08, 32'h0);
    check("acc0 ext after reset", rv, 32'h0);
    final_report;
  end

  initial begin
    repeat (5000) @(posedge sys_clk);
    n_fail++;
    final_report;
  end
endmodule : mth_datapath_tb

bind mth_datapath mth_datapath_props u_mth_datapath_props (.sys_clk(sys_clk), .rst_b(rst_b), .req(req),
  .wr_ff(wr_ff), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata_ff(reg_rdata_ff));

`default_nettype wire

// ==== sim/mth_regfile_model.sv ====
// Purpose : Data register file that takes the half-register writes
// Assumes : One write per cycle
// Notes   : Read port is combinational for the bench
`default_nettype none

module mth_regfile_model (
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rst_b,
  // Write from datapath
  input  wire mth_pkg::mth_wr_type wr,
  // Bench read port
  input  wire logic [2:0]          rd_idx,
  output logic [31:0]              rd_data
);
  logic [31:0] regs_ff [8];

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 8; i++) begin
        regs_ff[i] <= 32'h0;
      end
    end else if (wr.valid) begin
      if (wr.high_half_dest) begin
        regs_ff[wr.dest][31:16] <= wr.data;
      end else begin
        regs_ff[wr.dest][15:0] <= wr.data;
      end
    end
  end

  assign rd_data = regs_ff[rd_idx];
endmodule : mth_regfile_model

`default_nettype wire
